// [rtl/afp_defines.vh]
// constants for the angle filter and power control block
`ifndef AFP_DEFINES_VH
`define AFP_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define AFP_ADDR_CONFIG    8'h00
`define AFP_ADDR_ANGLE     8'h04
`define AFP_ADDR_STATUS    8'h08
`define AFP_ADDR_INT_STS   8'h0c
`define AFP_ADDR_INT_MASK  8'h10

// ****************************************
// config_word fields
// ****************************************
`define AFP_CFG_PM_LO      0
`define AFP_CFG_PM_HI      1
`define AFP_CFG_HYSTERESIS_SEL_LO    2
`define AFP_CFG_HYSTERESIS_SEL_HI    3
`define AFP_CFG_OUTPUT_STAGE_SEL_LO    4
`define AFP_CFG_OUTPUT_STAGE_SEL_HI    5
`define AFP_CFG_SF_LO      6
`define AFP_CFG_SF_HI      7
`define AFP_CFG_FTH_LO     8
`define AFP_CFG_FTH_HI     10
`define AFP_CFG_WD_BIT     13
`define AFP_CFG_WIDTH      14
`define AFP_CFG_RESET      14'h0000

// ****************************************
// status and interrupt bits
// ****************************************
`define AFP_INT_MAG_LOST   0
`define AFP_INT_MAG_FOUND  1
`define AFP_INT_WD_TRIP    2
`define AFP_INT_FAST_ON    3
`define AFP_INT_WIDTH      4
`define AFP_INT_RESET      4'h0

// ****************************************
// filter and output constants
// ****************************************
`define AFP_OUTPUT_STAGE_SEL_PWM       2'h2
`define AFP_FTH_OFF        3'h0
`define AFP_FRAC_BITS      8
`define AFP_FAST_SHIFT     3'h1
// slow shift per setting; each step halves the step response delay
`define AFP_SF_SHIFT_00    3'h4
`define AFP_SF_SHIFT_01    3'h3
`define AFP_SF_SHIFT_10    3'h2
`define AFP_SF_SHIFT_11    3'h1
`define AFP_WD_THRESH      12'h004
`define AFP_DEEPEST_MODE   2'h3
`define AFP_NORMAL_MODE    2'h0
`define AFP_WD_TIME_MS     60000
`define AFP_CLK_KHZ        25000

`endif

// [rtl/afp_angle_filter.v]
// angle post-filter, direction, hysteresis, magnet handling and power control
`timescale 1ns/1ps
// Function
// - slow filter delay selectable by two-bit code
// - fast filter off: output from slow filter
// - threshold code zero keeps slow filter only
// - per-code slow-to-fast and fast-to-slow thresholds
// - fast filter engaged only above threshold
// - fast filter halves the remaining error each sample
// - direction low: angle rises clockwise
// - direction high: angle rises counterclockwise
// - output hysteresis of zero to three LSB
// - weak field forces output low
// - weak field clears magnet present flag
// - three low-power modes plus normal
// - state machine enters and leaves low power
// - one idle minute within 4 LSB: deepest
// - watchdog runs only when enabled
// - output stage code 10 selects pulse width
`include "afp_defines.vh"

module afp_angle_filter #(
  parameter WD_CYCLES = `AFP_WD_TIME_MS * `AFP_CLK_KHZ
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        SAMPLE_VALID,
  input  wire [11:0] SAMPLE_ANGLE,
  input  wire        FIELD_LOW,
  input  wire        DIR_PIN,
  output reg  [11:0] OUT_ANGLE,
  output reg         OUT_VALID,
  output reg         OUT_FORCE_LOW,
  output reg         OUT_PWM_SEL,
  output reg  [1:0]  POWER_STATE,
  output reg         IRQ
);

  // ****************************************
  // power state machine codes
  // ****************************************
  localparam ST_NORMAL = 3'b001;
  localparam ST_LOW    = 3'b010;
  localparam ST_DEEP   = 3'b100;

  localparam FW = 12 + `AFP_FRAC_BITS;

  // ****************************************
  // declarations
  // ****************************************
  reg  [`AFP_CFG_WIDTH-1:0] cfg_r;
  reg  [`AFP_INT_WIDTH-1:0] int_sts_r;
  reg  [`AFP_INT_WIDTH-1:0] int_mask_r;
  reg  [`AFP_INT_WIDTH-1:0] int_ev;
  reg  [`AFP_INT_WIDTH-1:0] int_sts_nxt;
  reg                       dph_wr_r;
  reg  [7:0]                dph_addr_r;
  reg  [31:0]               rd_nxt;
  reg                       dir_s1_r;
  reg                       dir_s2_r;
  reg  [FW-1:0]             acc_r;
  reg  [FW-1:0]             acc_nxt;
  reg                       fast_r;
  reg                       fast_nxt;
  reg  [2:0]                shift;
  reg  [11:0]               s2f_th;
  reg  [11:0]               f2s_th;
  reg  [3:0]                hysteresis_sel_th;
  reg                       mag_r;
  reg  [11:0]               ref_r;
  reg  [31:0]               wd_cnt_r;
  reg  [2:0]                pst_r;
  reg  [2:0]                pst_nxt;
  wire [1:0]                pm_sel;
  wire [1:0]                sf_sel;
  wire [2:0]                fth_sel;
  wire [1:0]                hysteresis_sel_sel;
  wire                      wd_en;
  wire [11:0]               x_ang;
  wire [FW-1:0]             diff;
  wire [FW-1:0]             diff_abs;
  wire [11:0]               diff_lsb;
  wire [FW-1:0]             step;
  wire [11:0]               filt;
  wire [11:0]               od;
  wire [11:0]               od_abs;
  wire [11:0]               rd;
  wire [11:0]               rd_abs;
  wire                      moved;
  wire                      wd_hit;
  wire                      aph;

  assign pm_sel   = cfg_r[`AFP_CFG_PM_HI:`AFP_CFG_PM_LO];
  assign sf_sel   = cfg_r[`AFP_CFG_SF_HI:`AFP_CFG_SF_LO];
  assign fth_sel  = cfg_r[`AFP_CFG_FTH_HI:`AFP_CFG_FTH_LO];
  assign hysteresis_sel_sel = cfg_r[`AFP_CFG_HYSTERESIS_SEL_HI:`AFP_CFG_HYSTERESIS_SEL_LO];
  assign wd_en    = cfg_r[`AFP_CFG_WD_BIT];

  // ****************************************
  // direction pin synchroniser
  // ****************************************
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dir_s1_r <= 1'b0;
      dir_s2_r <= 1'b0;
    end else begin
      dir_s1_r <= DIR_PIN;
      dir_s2_r <= dir_s1_r;
    end
  end

  // mirrored angle counts the other way round the circle
  assign x_ang = dir_s2_r ? (12'h000 - SAMPLE_ANGLE) : SAMPLE_ANGLE;

  // ****************************************
  // filter
  // ****************************************
  // modular difference wraps cleanly across zero
  assign diff     = {x_ang, {`AFP_FRAC_BITS{1'b0}}} - acc_r;
  assign diff_abs = diff[FW-1] ? (~diff + 1'b1) : diff;
  assign diff_lsb = diff_abs[FW-1:`AFP_FRAC_BITS];
  assign filt     = acc_r[FW-1:`AFP_FRAC_BITS];

  always @* begin
    s2f_th = 12'h000;
    f2s_th = 12'h000;
    case (fth_sel)
      3'h1: begin s2f_th = 12'h006; f2s_th = 12'h001; end
      3'h2: begin s2f_th = 12'h007; f2s_th = 12'h001; end
      3'h3: begin s2f_th = 12'h009; f2s_th = 12'h001; end
      3'h4: begin s2f_th = 12'h012; f2s_th = 12'h002; end
      3'h5: begin s2f_th = 12'h015; f2s_th = 12'h002; end
      3'h6: begin s2f_th = 12'h018; f2s_th = 12'h002; end
      3'h7: begin s2f_th = 12'h00a; f2s_th = 12'h004; end
      default: begin s2f_th = 12'h000; f2s_th = 12'h000; end
    endcase
  end

  always @* begin
    fast_nxt = fast_r;
    if (fth_sel == `AFP_FTH_OFF) begin
      fast_nxt = 1'b0;
    end else if (!fast_r && diff_lsb > s2f_th) begin
      fast_nxt = 1'b1;
    end else if (fast_r && diff_lsb <= f2s_th) begin
      fast_nxt = 1'b0;
    end
  end

  always @* begin
    case (sf_sel)
      2'h0: shift = `AFP_SF_SHIFT_00;
      2'h1: shift = `AFP_SF_SHIFT_01;
      2'h2: shift = `AFP_SF_SHIFT_10;
      default: shift = `AFP_SF_SHIFT_11;
    endcase
    // half-step per sample: the fast path halves the remaining error on each sample
    if (fast_nxt) begin
      shift = `AFP_FAST_SHIFT;
    end
  end

  assign step = $signed(diff) >>> shift;

  always @* begin
    acc_nxt = acc_r;
    if (SAMPLE_VALID) begin
      acc_nxt = acc_r + step;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      acc_r  <= {FW{1'b0}};
      fast_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      if (SAMPLE_VALID) begin
        fast_r <= fast_nxt;
      end
    end
  end

  // ****************************************
  // hysteresis, magnet and output stage
  // ****************************************
  assign od     = filt - OUT_ANGLE;
  assign od_abs = od[11] ? (12'h000 - od) : od;

  always @* begin
    hysteresis_sel_th = {2'b00, hysteresis_sel_sel};
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OUT_ANGLE     <= 12'h000;
      OUT_VALID     <= 1'b0;
      OUT_FORCE_LOW <= 1'b1;
      OUT_PWM_SEL   <= 1'b0;
      mag_r         <= 1'b0;
    end else begin
      OUT_VALID <= 1'b0;
      if (od_abs > {8'h00, hysteresis_sel_th}) begin
        OUT_ANGLE <= filt;
        OUT_VALID <= 1'b1;
      end
      mag_r         <= ~FIELD_LOW;
      // drives low whatever the stage, analog or pulse width
      OUT_FORCE_LOW <= FIELD_LOW;
      OUT_PWM_SEL   <= (cfg_r[`AFP_CFG_OUTPUT_STAGE_SEL_HI:`AFP_CFG_OUTPUT_STAGE_SEL_LO] == `AFP_OUTPUT_STAGE_SEL_PWM);
    end
  end

  // ****************************************
  // inactivity watchdog
  // ****************************************
  assign rd     = OUT_ANGLE - ref_r;
  assign rd_abs = rd[11] ? (12'h000 - rd) : rd;
  assign moved  = rd_abs > `AFP_WD_THRESH;
  assign wd_hit = wd_en && (wd_cnt_r >= WD_CYCLES - 1);

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ref_r    <= 12'h000;
      wd_cnt_r <= 32'h00000000;
    end else if (!wd_en) begin
      wd_cnt_r <= 32'h00000000;
      ref_r    <= OUT_ANGLE;
    end else if (moved) begin
      wd_cnt_r <= 32'h00000000;
      ref_r    <= OUT_ANGLE;
    end else if (!wd_hit) begin
      wd_cnt_r <= wd_cnt_r + 32'h00000001;
    end
  end

  // ****************************************
  // power state machine
  // ****************************************
  always @* begin
    case (pst_r)
      ST_NORMAL: begin
        if (wd_hit) begin
          pst_nxt = ST_DEEP;
        end else if (pm_sel != `AFP_NORMAL_MODE && !fast_r) begin
          pst_nxt = ST_LOW;
        end else begin
          pst_nxt = ST_NORMAL;
        end
      end
      ST_LOW: begin
        if (wd_hit) begin
          pst_nxt = ST_DEEP;
        end else if (pm_sel == `AFP_NORMAL_MODE || fast_r || moved) begin
          pst_nxt = ST_NORMAL;
        end else begin
          pst_nxt = ST_LOW;
        end
      end
      ST_DEEP: begin
        if (!wd_en || moved) begin
          pst_nxt = ST_NORMAL;
        end else begin
          pst_nxt = ST_DEEP;
        end
      end
      default: pst_nxt = ST_NORMAL;
    endcase
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pst_r       <= ST_NORMAL;
      POWER_STATE <= `AFP_NORMAL_MODE;
    end else begin
      pst_r <= pst_nxt;
      case (pst_nxt)
        ST_LOW:  POWER_STATE <= pm_sel;
        ST_DEEP: POWER_STATE <= `AFP_DEEPEST_MODE;
        default: POWER_STATE <= `AFP_NORMAL_MODE;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always @* begin
    int_ev = `AFP_INT_RESET;
    int_ev[`AFP_INT_MAG_LOST]  = mag_r & FIELD_LOW;
    int_ev[`AFP_INT_MAG_FOUND] = ~mag_r & ~FIELD_LOW;
    int_ev[`AFP_INT_WD_TRIP]   = (pst_nxt == ST_DEEP) && (pst_r != ST_DEEP);
    int_ev[`AFP_INT_FAST_ON]   = SAMPLE_VALID & fast_nxt & ~fast_r;
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign aph = HSEL && HTRANS[1] && HREADY;

  always @* begin
    case (HADDR[7:0])
      `AFP_ADDR_CONFIG:   rd_nxt = {{(32-`AFP_CFG_WIDTH){1'b0}}, cfg_r};
      `AFP_ADDR_ANGLE:    rd_nxt = {20'h00000, OUT_ANGLE};
      `AFP_ADDR_STATUS:   rd_nxt = {25'h0000000, pst_r, POWER_STATE, fast_r, mag_r};
      `AFP_ADDR_INT_STS:  rd_nxt = {{(32-`AFP_INT_WIDTH){1'b0}}, int_sts_r};
      `AFP_ADDR_INT_MASK: rd_nxt = {{(32-`AFP_INT_WIDTH){1'b0}}, int_mask_r};
      default:            rd_nxt = 32'h00000000;
    endcase
    if (HADDR[31:8] != 24'h000000) begin
      rd_nxt = 32'h00000000;
    end
  end

  always @* begin
    int_sts_nxt = int_sts_r;
    if (dph_wr_r && dph_addr_r == `AFP_ADDR_INT_STS) begin
      int_sts_nxt = int_sts_r & ~HWDATA[`AFP_INT_WIDTH-1:0];
    end
    // a new event beats a clear in the same cycle
    int_sts_nxt = int_sts_nxt | int_ev;
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HRDATA     <= 32'h00000000;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      cfg_r      <= `AFP_CFG_RESET;
      int_sts_r  <= `AFP_INT_RESET;
      int_mask_r <= `AFP_INT_RESET;
      IRQ        <= 1'b0;
    end else begin
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
      dph_wr_r   <= aph && HWRITE && (HADDR[31:8] == 24'h000000);
      dph_addr_r <= HADDR[7:0];
      if (aph && !HWRITE) begin
        HRDATA <= rd_nxt;
      end
      if (dph_wr_r && dph_addr_r == `AFP_ADDR_CONFIG) begin
        cfg_r <= HWDATA[`AFP_CFG_WIDTH-1:0];
      end
      if (dph_wr_r && dph_addr_r == `AFP_ADDR_INT_MASK) begin
        int_mask_r <= HWDATA[`AFP_INT_WIDTH-1:0];
      end
      int_sts_r <= int_sts_nxt;
      IRQ       <= |(int_sts_nxt & int_mask_r);
    end
  end

endmodule // afp_angle_filter

// [tb/afp_angle_filter_assertions.sv]
// port checker for the angle filter block
`timescale 1ns/1ps
module afp_checker #(
  parameter WD_CYCLES = 50
) (
  input logic        CLK_SYS,
  input logic        RST,
  input logic        HSEL,
  input logic [31:0] HADDR,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic [2:0]  HSIZE,
  input logic [31:0] HWDATA,
  input logic        HREADY,
  input logic [31:0] HRDATA,
  input logic        HREADYOUT,
  input logic        HRESP,
  input logic        SAMPLE_VALID,
  input logic [11:0] SAMPLE_ANGLE,
  input logic        FIELD_LOW,
  input logic        DIR_PIN,
  input logic [11:0] OUT_ANGLE,
  input logic        OUT_VALID,
  input logic        OUT_FORCE_LOW,
  input logic        OUT_PWM_SEL,
  input logic [1:0]  POWER_STATE,
  input logic        IRQ
);
  // ****
  // shadow of watchdog enable and output stage code
  // ****
  logic [2:0] wr_r;
  logic [2:0] cfg_r;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_r  <= 3'h0;
      cfg_r <= 3'h0;
    end else begin
      wr_r <= {wr_r[1:0], HSEL & HTRANS[1] & HREADY & HWRITE & (HADDR == 32'h0)};
      if (wr_r[0]) cfg_r <= {HWDATA[13], HWDATA[5:4]};
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  chk_force_low: assert property (FIELD_LOW |=> OUT_FORCE_LOW)
    else $error("output not forced low");
  chk_force_free: assert property (!FIELD_LOW |=> !OUT_FORCE_LOW)
    else $error("output held low");
  chk_valid_cause: assert property (OUT_VALID |->
    $past(SAMPLE_VALID) || $past(SAMPLE_VALID, 2) || $past(SAMPLE_VALID, 3))
    else $error("angle moved without a sample");
  chk_valid_moves: assert property (OUT_VALID |-> OUT_ANGLE != $past(OUT_ANGLE))
    else $error("valid without change");
  chk_angle_hold: assert property (!OUT_VALID |-> $stable(OUT_ANGLE))
    else $error("angle toggled silently");
  chk_pwm_sel: assert property (wr_r == 3'h0 |-> OUT_PWM_SEL == (cfg_r[1:0] == 2'h2))
    else $error("pwm select wrong");
  chk_deep_quiet: assert property ($rose(POWER_STATE == 2'h3) |->
    !$past(OUT_VALID) && $stable(OUT_ANGLE))
    else $error("deep mode while moving");
  // a jump above twice the threshold always leaves the reference band
  chk_deep_exit: assert property (cfg_r[2] && POWER_STATE == 2'h3 && OUT_VALID &&
    (12'(OUT_ANGLE - $past(OUT_ANGLE)) inside {[12'd9:12'd4087]}) |-> ##[1:3] POWER_STATE != 2'h3)
    else $error("low power kept after movement");
  chk_bus_okay: assert property (HSEL && HTRANS[1] |=> HREADYOUT && !HRESP)
    else $error("bus not ready or error");
endmodule // afp_checker

bind afp_angle_filter afp_checker #(.WD_CYCLES(WD_CYCLES)) u_afp_checker (.CLK_SYS, .RST, .HSEL,
  .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SAMPLE_VALID,
  .SAMPLE_ANGLE, .FIELD_LOW, .DIR_PIN, .OUT_ANGLE, .OUT_VALID, .OUT_FORCE_LOW, .OUT_PWM_SEL,
  .POWER_STATE, .IRQ);

// [tb/afp_front_end.sv]
// model of the measurement front end that paces raw angle samples
`timescale 1ns/1ps
module afp_front_end (
  input  wire        clk,
  input  wire        rst,
  input  wire [2:0]  gap,
  input  wire [11:0] target,
  output reg         valid,
  output reg  [11:0] angle
);
  // ****
  // sample pacing
  // ****
  reg [2:0] cnt_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
      valid <= 1'b0;
      angle <= 12'h0;
    end else begin
      cnt_r <= (cnt_r >= gap) ? 3'h0 : cnt_r + 3'h1;
      valid <= (cnt_r == gap);
      // not held between samples, so stale data cannot pass
      angle <= (cnt_r == gap) ? target : ~angle;
    end
  end
endmodule // afp_front_end

// [tb/angle_filter_power_control_test.sv]
// bench for the angle filter and power control block
`timescale 1ns/1ps
module angle_filter_power_control_test;
  logic        CLK_SYS = 0, RST = 1, HSEL = 0, HWRITE = 0, FIELD_LOW = 0, DIR_PIN = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, rd;
  logic [1:0]  HTRANS = 0;
  logic [2:0]  HSIZE = 3'h2, gap = 3'h2;
  logic [11:0] tgt = 0;
  wire  [31:0] HRDATA;
  wire  [11:0] OUT_ANGLE, SAMPLE_ANGLE;
  wire  [1:0]  POWER_STATE;
  wire         HREADYOUT, HRESP, SAMPLE_VALID, OUT_VALID, OUT_FORCE_LOW, OUT_PWM_SEL, IRQ;
  integer      err_count = 0, samples_checked = 0, i, j, n, prv;
  integer      s2f [1:7] = '{6, 7, 9, 18, 21, 24, 10};
  always #20 CLK_SYS = ~CLK_SYS;
  afp_front_end u_afp_front_end (.clk(CLK_SYS), .rst(RST), .gap(gap), .target(tgt),
    .valid(SAMPLE_VALID), .angle(SAMPLE_ANGLE));
  afp_angle_filter #(.WD_CYCLES(50)) u_afp_angle_filter (.CLK_SYS, .RST, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .SAMPLE_VALID, .SAMPLE_ANGLE, .FIELD_LOW, .DIR_PIN, .OUT_ANGLE, .OUT_VALID,
    .OUT_FORCE_LOW, .OUT_PWM_SEL, .POWER_STATE, .IRQ);
  // ****
  // tasks
  // ****
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rdy;
    integer k;
    k = 0;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1 && k < 20) begin
      @(posedge CLK_SYS);
      k++;
    end
    if (k == 20) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy();
    rd = HRDATA;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // modular distance, the angle wraps at a full turn
  task automatic near(input string nm, input integer exp, input logic [11:0] got, input integer tol);
    logic [11:0] d;
    d = got - exp[11:0];
    samples_checked++;
    if ((d <= tol || d >= 4096 - tol) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  task automatic samp(input integer m);
    integer k, c;
    k = 0;
    // a pulse seen at the first edge still carries the old target
    @(posedge CLK_SYS);
    for (c = 0; c < 8 * m && k < m; c++) begin
      @(posedge CLK_SYS);
      if (SAMPLE_VALID === 1'b1) k++;
    end
    repeat (3) @(posedge CLK_SYS);
  endtask
  task automatic rst_dut(input logic [31:0] cfg);
    RST <= 1'b1;
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    bus(1'b1, 8'h00, cfg);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(40452));
    gap <= 3'h2 + 3'($urandom % 3);
    rst_dut(32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk("mask reset", 0, rd);
    bus(1'b1, 8'h40, 32'hffff);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 0, rd);
    for (i = 0; i < 2; i++) begin
      DIR_PIN <= i[0];
      tgt <= 12'h0;
      rst_dut(32'hc0);
      n = 100 + $urandom % 3000;
      tgt <= n[11:0];
      samp(40);
      near("angle out", i ? 4096 - n : n, OUT_ANGLE, 1);
      bus(1'b0, 8'h04, 32'h0);
      near("angle reg", i ? 4096 - n : n, rd[11:0], 1);
    end
    DIR_PIN <= 1'b0;
    tgt <= 12'h0;
    rst_dut(32'hcc);
    tgt <= 12'h3;
    samp(20);
    chk("hysteresis_sel hold", 0, OUT_ANGLE);
    tgt <= 12'd20;
    samp(20);
    near("hysteresis_sel move", 20, OUT_ANGLE, 4);
    prv = 1000;
    for (i = 0; i < 5; i++) begin
      tgt <= 12'h0;
      rst_dut(i < 4 ? i << 6 : 32'h100);
      samp(2);
      tgt <= 12'd1500;
      n = 0;
      while (n < 400 && (OUT_ANGLE - 12'd1500 + 12'd8) > 12'd16) begin
        samp(1);
        n++;
      end
      chk("faster", 1, n < (i < 4 ? prv : j));
      bus(1'b0, 8'h0c, 32'h0);
      chk("fast flag", i == 4, rd[3]);
      if (i == 0) j = n;
      prv = n;
    end
    for (i = 1; i < 8; i++) begin
      for (j = 0; j < 2; j++) begin
        tgt <= 12'h0;
        rst_dut(i << 8 | 32'hc0);
        samp(2);
        tgt <= 12'(s2f[i] + j);
        samp(1);
        bus(1'b0, 8'h0c, 32'h0);
        chk("threshold", j, rd[3]);
      end
    end
    bus(1'b1, 8'h00, 32'hc0);
    samp(30);
    FIELD_LOW <= 1'b1;
    samp(1);
    bus(1'b0, 8'h08, 32'h0);
    chk("present", 0, rd[0]);
    chk("force low", 1, OUT_FORCE_LOW);
    FIELD_LOW <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    chk("masked irq", 0, IRQ);
    bus(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge CLK_SYS);
    chk("irq", 1, IRQ);
    bus(1'b1, 8'h0c, 32'hf);
    bus(1'b0, 8'h0c, 32'h0);
    chk("cleared", 0, rd[0]);
    chk("irq off", 0, IRQ);
    for (i = 1; i < 4; i++) begin
      bus(1'b1, 8'h00, 32'hc0);
      repeat (3) @(posedge CLK_SYS);
      bus(1'b1, 8'h00, i | 32'hc0);
      repeat (4) @(posedge CLK_SYS);
      chk("power mode", i, POWER_STATE);
    end
    bus(1'b1, 8'h00, 32'h20c0);
    repeat (30) @(posedge CLK_SYS);
    chk("early deep", 0, POWER_STATE);
    n = 0;
    while (POWER_STATE !== 2'h3 && n < 100) begin
      @(posedge CLK_SYS);
      n++;
    end
    chk("deep", 3, POWER_STATE);
    tgt <= 12'd2000;
    samp(3);
    chk("woken", 0, POWER_STATE);
    bus(1'b1, 8'h00, 32'he0);
    repeat (120) @(posedge CLK_SYS);
    chk("wd off", 0, POWER_STATE);
    chk("pwm", 1, OUT_PWM_SEL);
    tally_and_finish;
  end
  initial begin
    #4000000;
    err_count++;
    tally_and_finish;
  end
endmodule // angle_filter_power_control_test
